// ===== core/pm_irq_routing_power_state_cfg.sv
`timescale 1ns/10ps
module pm_irq_routing_power_state_cfg (
  input wire logic i_clk,                           // Bus clock, 25 MHz.
  input wire logic i_srst,                          // Synchronous reset, active high.
  input wire pm_cfg_pkg::cfg_req_s i_cfg,           // Configuration byte access.
  output pm_cfg_pkg::cfg_rsp_s o_cfg,               // Configuration answer.
  input wire pm_cfg_pkg::pin_s i_pins,              // Asynchronous pins.
  input wire logic i_sci_source,                    // Other control interrupt sources.
  input wire logic i_gpio_event,                    // Enabled GPIO status is set.
  input wire logic i_trap_event,                    // Enabled IO trap status is set.
  input wire logic i_ctl_irq_mode,                  // 1 selects control, 0 management interrupt.
  input wire logic i_route_to_io_apic,              // Control interrupt goes to the IO-APIC.
  input wire logic i_wdog_irq_status,               // Watchdog interrupt status.
  input wire logic i_intruder_status,               // Intruder status routed to IRQ.
  input wire logic i_wdog_to_ctl_irq,               // Watchdog routed to control interrupt.
  input wire logic [2:0] i_pnp_pin_enable,          // Pins configured as interrupt inputs.
  input wire logic [1:0] i_csel_pin_enable,         // Pins configured as chip selects.
  input wire logic i_io_low_hit_a,                  // IO monitor 3 low-bit match.
  input wire logic i_io_upper_hit_a,                // IO monitor 3 bits 10:8 match.
  input wire logic i_io_low_hit_b,                  // IO monitor 4 low-bit match.
  input wire logic i_io_upper_hit_b,                // IO monitor 4 bits 10:8 match.
  input wire logic i_mem_hit_a,                     // Memory monitor 1 match.
  input wire logic i_mem_hit_b,                     // Memory monitor 2 match.
  input wire logic i_enter_mech_off,                // Pulse: system enters mechanical off.
  input wire logic [2:0] i_cur_state,               // Current state, failure coding.
  input wire logic i_full_on_entry,                 // Pulse: system enters full-on.
  input wire logic [2:0] i_from_state,              // State left on full-on entry.
  input wire logic i_reset_port_reset,              // Pulse: reset port wrote 11b.
  output logic [15:0] o_pic_irq,                    // Legacy interrupt lines.
  output logic [3:0] o_apic_irq,                    // APIC lines 20 to 23.
  output logic o_sci_req,                           // Control interrupt request.
  output logic o_smi_req,                           // Management interrupt request.
  output logic o_pnp_chip_select_a_n,               // Chip select A, active low.
  output logic o_pnp_chip_select_b_n,               // Chip select B, active low.
  output logic o_claim_isa,                         // Claim cycle and forward to ISA.
  output logic o_smbus_alert_n,                     // Alert to management logic, active low.
  output logic o_usb_overcurrent_1_n,               // Overcurrent to USB, active low.
  output logic o_off_to_soft_off                    // Action on auxiliary power.
);
  import pm_cfg_pkg::*;

  state_s state_reg;
  state_s state_next;
  logic [15:0] pnp_line [3];
  logic ctl_event;
  logic wdog_src;
  logic fail_now;
  logic plane_up;
  logic wr_hit;

  // Interrupt lines that the pin fields may never drive.
  function automatic logic line_ok(input logic [3:0] v);
    line_ok = (v != 4'h0) && (v != 4'h2) && (v != 4'h8) && (v != 4'hD);
  endfunction

  // One decoder per interrupt pin; a field acts only while its pin has the function.
  for (genvar g = 0; g < 3; g++) begin : g_pnp
    logic [3:0] sel;
    assign sel = state_reg.pnp_irq_sel[g*4 +: 4];
    assign pnp_line[g] = (i_pnp_pin_enable[g] && state_reg.sync2.pnp_irq[g] && line_ok(sel)) ?
                         (16'h0001 << sel) : 16'h0000;
  end

  // Shared event terms.
  assign wdog_src = i_wdog_irq_status | i_intruder_status;
  assign ctl_event = i_sci_source
                   | (state_reg.sci_cfg[GPIO_EN_BIT] & i_gpio_event)
                   | (state_reg.sci_cfg[TRAP_EN_BIT] & i_trap_event)
                   | (i_wdog_to_ctl_irq & wdog_src);
  assign fail_now = i_enter_mech_off
                  | (state_reg.sync3.power_good & ~state_reg.sync2.power_good
                     & ~state_reg.sync2.power_on_request_n);
  assign plane_up = state_reg.sync2.aon_valid & ~state_reg.sync3.aon_valid;
  assign wr_hit = i_cfg.sel & i_cfg.wr;

  // Next-state logic for the whole block.
  always_comb begin
    logic [3:0] sci_sel;
    logic [2:0] wsel;
    logic io_a;
    logic io_b;
    logic hit_a;
    logic hit_b;
    sci_sel = state_reg.sci_cfg[SCI_SEL_LSB +: 4];
    wsel = state_reg.pnp_irq_sel[WDOG_SEL_LSB +: 3];
    io_a = 1'b0;
    io_b = 1'b0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    state_next = state_reg;

    // Two-stage pin synchronisers and a third stage for edge detection.
    state_next.sync1 = i_pins;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;

    // Register writes; reserved bits stay zero.
    if (wr_hit) begin
      case (i_cfg.addr)
        OFS_SCI_ROUTE: begin
          state_next.sci_cfg = i_cfg.wdata & SCI_ROUTE_WMASK;
        end
        OFS_POWER_STATE: begin
          if (i_cfg.wdata[FAIL_CLR_BIT]) begin
            state_next.failure_state = FAIL_NONE;
          end
          state_next.off_to_soft_off = i_cfg.wdata[SOFT_OFF_BIT];
          if (i_cfg.wdata[AON_STS_BIT]) begin
            state_next.always_on_reset_status = 1'b0;
          end
        end
        OFS_PNP_IRQ_LO: begin
          state_next.pnp_irq_sel[7:0] = i_cfg.wdata;
        end
        OFS_PNP_IRQ_HI: begin
          state_next.pnp_irq_sel[15:8] = i_cfg.wdata;
        end
        OFS_PNP_CS_LO: begin
          state_next.pnp_cs[7:0] = i_cfg.wdata & PNP_CS_WMASK[7:0];
        end
        OFS_PNP_CS_HI: begin
          state_next.pnp_cs[15:8] = i_cfg.wdata & PNP_CS_WMASK[15:8];
        end
        default: begin
          state_next.rsp.hit = 1'b0;
        end
      endcase
    end

    // Previous power state, recorded on each entry to full-on.
    if (i_full_on_entry) begin
      state_next.previous_power_state = i_from_state;
    end

    // A failure is captured once and retained; a write clear of a held code wins over a new failure.
    if (fail_now && state_reg.failure_state == FAIL_NONE) begin
      state_next.failure_state = i_cur_state;
    end

    // The reset port clears the soft-off choice.
    if (i_reset_port_reset) begin
      state_next.off_to_soft_off = 1'b0;
    end

    // Plane loss sets the status; plane return restores the defaults.
    if (!state_reg.sync2.aon_valid) begin
      state_next.always_on_reset_status = 1'b1;
    end
    if (plane_up) begin
      state_next.failure_state = FAIL_NONE;
      state_next.off_to_soft_off = 1'b0;
    end

    // Control interrupt routing to the legacy controller.
    state_next.sci_vec = 16'h0000;
    if (ctl_event && i_ctl_irq_mode && sci_sel != 4'h0 && !i_route_to_io_apic) begin
      state_next.sci_vec = 16'h0001 << sci_sel;
    end
    state_next.sci_req = ctl_event & i_ctl_irq_mode;
    state_next.smi_req = ctl_event & ~i_ctl_irq_mode;

    // Interrupt pins and the IRQ12 pin role.
    state_next.pnp_vec = pnp_line[0] | pnp_line[1] | pnp_line[2];
    state_next.smbus_alert_n = 1'b1;
    state_next.usb_overcurrent_1_n = 1'b1;
    case (state_reg.pnp_cs[IRQ12_FN_LSB +: 2])
      IRQ12_FN_IRQ: begin
        if (state_reg.sync2.irq12) begin
          state_next.pnp_vec[IRQ12_LINE] = 1'b1;
        end
      end
      IRQ12_FN_SMBUS: begin
        state_next.smbus_alert_n = ~state_reg.sync2.irq12;
      end
      IRQ12_FN_USB: begin
        state_next.usb_overcurrent_1_n = ~state_reg.sync2.irq12;
      end
      default: begin
        state_next.smbus_alert_n = 1'b1;
      end
    endcase

    // Watchdog interrupt line selection.
    state_next.wdog_vec = 16'h0000;
    state_next.apic_vec = 4'h0;
    if (state_reg.pnp_irq_sel[WDOG_EN_BIT] && !i_wdog_to_ctl_irq && wdog_src) begin
      if (wsel[2]) begin
        state_next.apic_vec = 4'h1 << wsel[1:0];
      end else if (wsel != WDOG_SEL_RSVD) begin
        state_next.wdog_vec = 16'h0001 << (WDOG_IRQ_BASE + {2'b00, wsel[1:0]});
      end
    end

    // Chip select decode; the upper mask removes bits 10:8 from the IO match.
    io_a = i_io_low_hit_a & (state_reg.pnp_cs[CSA_UBM_BIT] | i_io_upper_hit_a);
    io_b = i_io_low_hit_b & (state_reg.pnp_cs[CSB_UBM_BIT] | i_io_upper_hit_b);
    hit_a = i_csel_pin_enable[0] & ((state_reg.pnp_cs[CSA_IO_BIT] & io_a)
                                  | (state_reg.pnp_cs[CSA_MEM_BIT] & i_mem_hit_a));
    hit_b = i_csel_pin_enable[1] & ((state_reg.pnp_cs[CSB_IO_BIT] & io_b)
                                  | (state_reg.pnp_cs[CSB_MEM_BIT] & i_mem_hit_b));
    state_next.csel_a_n = ~hit_a;
    state_next.csel_b_n = ~hit_b;
    state_next.claim_isa = hit_a | hit_b;

    // Read answer one cycle after the access.
    state_next.rsp.ack = i_cfg.sel;
    state_next.rsp.hit = 1'b0;
    state_next.rsp.rdata = 8'h00;
    if (i_cfg.sel) begin
      state_next.rsp.hit = 1'b1;
      case (i_cfg.addr)
        OFS_SCI_ROUTE: begin
          state_next.rsp.rdata = state_reg.sci_cfg;
        end
        OFS_POWER_STATE: begin
          state_next.rsp.rdata = {state_reg.always_on_reset_status, state_reg.off_to_soft_off,
                                  state_reg.failure_state, state_reg.previous_power_state};
        end
        OFS_PNP_IRQ_LO: begin
          state_next.rsp.rdata = state_reg.pnp_irq_sel[7:0];
        end
        OFS_PNP_IRQ_HI: begin
          state_next.rsp.rdata = state_reg.pnp_irq_sel[15:8];
        end
        OFS_PNP_CS_LO: begin
          state_next.rsp.rdata = state_reg.pnp_cs[7:0];
        end
        OFS_PNP_CS_HI: begin
          state_next.rsp.rdata = state_reg.pnp_cs[15:8];
        end
        default: begin
          state_next.rsp.hit = 1'b0;
        end
      endcase
    end

    // Bus reset clears volatile state; always-on fields keep their values.
    if (i_srst) begin
      state_next.sync1 = '0;
      state_next.sync2 = '0;
      state_next.sync3 = '0;
      state_next.sync1.aon_valid = 1'b1;
      state_next.sync2.aon_valid = 1'b1;
      state_next.sync3.aon_valid = 1'b1;
      state_next.sci_cfg = SCI_ROUTE_RST;
      state_next.pnp_irq_sel = PNP_IRQ_RST;
      state_next.pnp_cs = PNP_CS_RST;
      state_next.sci_vec = 16'h0000;
      state_next.pnp_vec = 16'h0000;
      state_next.wdog_vec = 16'h0000;
      state_next.apic_vec = 4'h0;
      state_next.sci_req = 1'b0;
      state_next.smi_req = 1'b0;
      state_next.csel_a_n = 1'b1;
      state_next.csel_b_n = 1'b1;
      state_next.claim_isa = 1'b0;
      state_next.smbus_alert_n = 1'b1;
      state_next.usb_overcurrent_1_n = 1'b1;
      state_next.rsp = '0;
    end
  end

  // State register.
  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from the state register.
  assign o_cfg = state_reg.rsp;
  assign o_pic_irq = state_reg.sci_vec | state_reg.pnp_vec | state_reg.wdog_vec;
  assign o_apic_irq = state_reg.apic_vec;
  assign o_sci_req = state_reg.sci_req;
  assign o_smi_req = state_reg.smi_req;
  assign o_pnp_chip_select_a_n = state_reg.csel_a_n;
  assign o_pnp_chip_select_b_n = state_reg.csel_b_n;
  assign o_claim_isa = state_reg.claim_isa;
  assign o_smbus_alert_n = state_reg.smbus_alert_n;
  assign o_usb_overcurrent_1_n = state_reg.usb_overcurrent_1_n;
  assign o_off_to_soft_off = state_reg.off_to_soft_off;

  // Checks on routing and power-state behaviour.
  a_sci_zero_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.sci_cfg[3:0] == 4'h0) |=> (state_reg.sci_vec == 16'h0000))
    else $error("control interrupt drove a line while select is zero");
  a_sci_line_select: assert property (@(posedge i_clk) disable iff (i_srst)
    (ctl_event && i_ctl_irq_mode && !i_route_to_io_apic && state_reg.sci_cfg[3:0] != 4'h0)
    |=> (state_reg.sci_vec == (16'h0001 << $past(state_reg.sci_cfg[3:0]))))
    else $error("control interrupt not on the selected line");
  a_apic_bypass: assert property (@(posedge i_clk) disable iff (i_srst)
    i_route_to_io_apic |=> (state_reg.sci_vec == 16'h0000))
    else $error("control interrupt reached legacy controller under APIC routing");
  a_gpio_ctl_path: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.sci_cfg[GPIO_EN_BIT] && i_gpio_event) |=> (o_sci_req || o_smi_req))
    else $error("enabled GPIO event raised no interrupt");
  a_trap_mode_pick: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.sci_cfg[TRAP_EN_BIT] && i_trap_event && !i_ctl_irq_mode) |=> (o_smi_req && !o_sci_req))
    else $error("trap event not sent as management interrupt");
  a_fail_capture: assert property (@(posedge i_clk) disable iff (i_srst)
    (fail_now && state_reg.failure_state == FAIL_NONE && !plane_up)
    |=> (state_reg.failure_state == $past(i_cur_state)))
    else $error("power failure not captured");
  a_fail_write_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_hit && i_cfg.addr == OFS_POWER_STATE && i_cfg.wdata[FAIL_CLR_BIT] && !fail_now)
    |=> (state_reg.failure_state == FAIL_NONE))
    else $error("write one did not restore no-failure code");
  a_plane_status_set: assert property (@(posedge i_clk) disable iff (i_srst)
    !state_reg.sync2.aon_valid |=> state_reg.always_on_reset_status)
    else $error("plane loss did not set status");
  a_wdog_apic_line: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.pnp_irq_sel[15:12] == 4'hC && wdog_src && !i_wdog_to_ctl_irq) |=> (o_apic_irq == 4'h1))
    else $error("watchdog not on APIC line 20");
  a_irq12_usb_role: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.pnp_cs[10:9] == IRQ12_FN_USB) |=> (!o_pic_irq[12] || state_reg.sci_vec[12]
                                                  || $past(pnp_line[0][12] | pnp_line[1][12] | pnp_line[2][12])))
    else $error("IRQ12 pin drove line 12 in overcurrent role");
  // Checks on the always-on fields, pin gating and decode.
  a_plane_up_defaults: assert property (@(posedge i_clk) disable iff (i_srst)
    plane_up |=> (state_reg.failure_state == FAIL_NONE && !o_off_to_soft_off))
    else $error("plane return did not restore defaults");
  a_port_soft_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    i_reset_port_reset |=> !o_off_to_soft_off)
    else $error("reset port did not clear soft-off");
  a_prev_state_rec: assert property (@(posedge i_clk) disable iff (i_srst)
    i_full_on_entry |=> (state_reg.previous_power_state == $past(i_from_state)))
    else $error("previous state not recorded");
  a_pnp_gate_off: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_pnp_pin_enable == 3'b000 && state_reg.pnp_cs[10:9] != IRQ12_FN_IRQ && !ctl_event && !wdog_src)
    |=> (o_pic_irq == 16'h0000))
    else $error("legacy line driven with sources off");
  a_wdog_line_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.pnp_irq_sel[14:12] == WDOG_SEL_RSVD || i_wdog_to_ctl_irq)
    |=> (state_reg.wdog_vec == 16'h0000 && o_apic_irq == 4'h0))
    else $error("watchdog line driven while disabled");
  a_csel_pin_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_csel_pin_enable[0] |=> o_pnp_chip_select_a_n)
    else $error("chip select A without pin function");
  a_csel_upper_mask: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_reg.pnp_cs[CSA_UBM_BIT] && state_reg.pnp_cs[CSA_IO_BIT] && i_io_low_hit_a && i_csel_pin_enable[0])
    |=> (!o_pnp_chip_select_a_n && o_claim_isa))
    else $error("upper mask did not drop bits 10:8");

endmodule

// ===== inc/pm_cfg_pkg.sv
// Behaviour
// - Control interrupt drives selected IRQ; zero disables.
// - IO-APIC routing bypasses the legacy controller.
// - GPIO enable raises control or management interrupt.
// - Previous state field records state before full-on.
// - Power failure captures the current system state.
// - Failure field codes; 4h means no failure.
// - Failure field becomes 4h when plane valid.
// - Writing one to bit 3 sets 4h.
// - Soft-off bit chooses action on auxiliary power.
// - Soft-off bit cleared by plane valid, reset port.
// - Plane loss sets status; write one clears.
// - Three pin IRQ fields, reserved lines, pin gating.
// - Watchdog select field picks IRQ or APIC line.
// - Watchdog enable asserts line unless routed elsewhere.
// - Chip select A on IO range three.
// - Chip select A on memory range one.
// - Chip select B on IO four, memory two.
// - IRQ12 pin function field selects pin role.
// - Upper mask drops IO address bits 10:8.
package pm_cfg_pkg;

  // Configuration offsets inside function 3, byte addressed.
  localparam logic [7:0] OFS_SCI_ROUTE = 8'h42;
  localparam logic [7:0] OFS_POWER_STATE = 8'h43;
  localparam logic [7:0] OFS_PNP_IRQ_LO = 8'h44;
  localparam logic [7:0] OFS_PNP_IRQ_HI = 8'h45;
  localparam logic [7:0] OFS_PNP_CS_LO = 8'h46;
  localparam logic [7:0] OFS_PNP_CS_HI = 8'h47;

  // Reset values and writable bit masks.
  localparam logic [7:0] SCI_ROUTE_RST = 8'h00;
  localparam logic [15:0] PNP_IRQ_RST = 16'h0000;
  localparam logic [15:0] PNP_CS_RST = 16'h0000;
  localparam logic [7:0] SCI_ROUTE_WMASK = 8'h3F;
  localparam logic [15:0] PNP_CS_WMASK = 16'h1E0F;

  // Field positions.
  localparam int SCI_SEL_LSB = 0;
  localparam int GPIO_EN_BIT = 4;
  localparam int TRAP_EN_BIT = 5;
  localparam int FAIL_CLR_BIT = 3;
  localparam int SOFT_OFF_BIT = 6;
  localparam int AON_STS_BIT = 7;
  localparam int WDOG_SEL_LSB = 12;
  localparam int WDOG_EN_BIT = 15;
  localparam int CSA_IO_BIT = 0;
  localparam int CSA_MEM_BIT = 1;
  localparam int CSB_IO_BIT = 2;
  localparam int CSB_MEM_BIT = 3;
  localparam int IRQ12_FN_LSB = 9;
  localparam int CSA_UBM_BIT = 11;
  localparam int CSB_UBM_BIT = 12;

  // Codes.
  localparam logic [2:0] FAIL_NONE = 3'h4;
  localparam logic [2:0] WDOG_SEL_RSVD = 3'h3;
  localparam logic [3:0] WDOG_IRQ_BASE = 4'h9;
  localparam logic [3:0] IRQ12_LINE = 4'hC;
  localparam logic [1:0] IRQ12_FN_IRQ = 2'h0;
  localparam logic [1:0] IRQ12_FN_SMBUS = 2'h2;
  localparam logic [1:0] IRQ12_FN_USB = 2'h3;

  // Configuration access from the host bridge.
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [7:0] rdata;
  } cfg_rsp_s;

  // Pins from outside the clock domain.
  typedef struct packed {
    logic aon_valid;
    logic power_good;
    logic power_on_request_n;
    logic [2:0] pnp_irq;
    logic irq12;
  } pin_s;

  typedef struct packed {
    pin_s sync1;
    pin_s sync2;
    pin_s sync3;
    logic [7:0] sci_cfg;
    logic [15:0] pnp_irq_sel;
    logic [15:0] pnp_cs;
    logic [2:0] previous_power_state;
    logic [2:0] failure_state;
    logic off_to_soft_off;
    logic always_on_reset_status;
    logic [15:0] sci_vec;
    logic [15:0] pnp_vec;
    logic [15:0] wdog_vec;
    logic [3:0] apic_vec;
    logic sci_req;
    logic smi_req;
    logic csel_a_n;
    logic csel_b_n;
    logic claim_isa;
    logic smbus_alert_n;
    logic usb_overcurrent_1_n;
    cfg_rsp_s rsp;
  } state_s;

endpackage

// ===== testbench/pm_irq_routing_power_state_cfg_tb.sv
`timescale 1ns/10ps
module pm_irq_routing_power_state_cfg_tb;
  import pm_cfg_pkg::*;
  logic i_clk, i_srst, sci_src, gpio_ev, trap_ev, mode, to_apic, wd_sts, intr_sts, wd_to_ctl;
  logic lo_a, up_a, lo_b, up_b, mem_a, mem_b, mech_off, fon_entry, port_rst;
  logic sci_req, smi_req, cs_a_n, cs_b_n, claim, smb_n, usb_n, soft_off;
  cfg_req_s cfg;
  cfg_rsp_s rsp;
  pin_s pins;
  logic [2:0] pnp_en, cur_state, from_state;
  logic [1:0] cs_en;
  logic [15:0] pic;
  logic [3:0] apic;
  logic [7:0] rd;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  pm_irq_routing_power_state_cfg dut (.i_clk(i_clk), .i_srst(i_srst), .i_cfg(cfg), .o_cfg(rsp), .i_pins(pins),
    .i_sci_source(sci_src), .i_gpio_event(gpio_ev), .i_trap_event(trap_ev), .i_ctl_irq_mode(mode),
    .i_route_to_io_apic(to_apic), .i_wdog_irq_status(wd_sts), .i_intruder_status(intr_sts),
    .i_wdog_to_ctl_irq(wd_to_ctl), .i_pnp_pin_enable(pnp_en), .i_csel_pin_enable(cs_en),
    .i_io_low_hit_a(lo_a), .i_io_upper_hit_a(up_a), .i_io_low_hit_b(lo_b), .i_io_upper_hit_b(up_b),
    .i_mem_hit_a(mem_a), .i_mem_hit_b(mem_b), .i_enter_mech_off(mech_off), .i_cur_state(cur_state),
    .i_full_on_entry(fon_entry), .i_from_state(from_state), .i_reset_port_reset(port_rst),
    .o_pic_irq(pic), .o_apic_irq(apic), .o_sci_req(sci_req), .o_smi_req(smi_req),
    .o_pnp_chip_select_a_n(cs_a_n), .o_pnp_chip_select_b_n(cs_b_n), .o_claim_isa(claim),
    .o_smbus_alert_n(smb_n), .o_usb_overcurrent_1_n(usb_n), .o_off_to_soft_off(soft_off));

  // The clock toggles every 20 ns, half the period of 40 ns.
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end

  // A hang is cut short once the cycle budget is spent.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n rising edges and lets their updates land.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One configuration byte access; the answer is sampled in the ack cycle.
  task automatic cfg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic hit);
    @(posedge i_clk);
    cfg <= '{sel: 1'h1, wr: wr, addr: a, wdata: d};
    @(posedge i_clk);
    cfg.sel <= 1'h0;
    #1;
    chk("ack", {15'h0000, rsp.ack}, 16'h0001);
    chk("hit", {15'h0000, rsp.hit}, {15'h0000, hit});
    rd = rsp.rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cfg_acc(1'h0, a, 8'h00, 1'h1);
    chk("rdata", {8'h00, rd}, {8'h00, exp});
  endtask

  // Reset values, reserved bits and an unmapped offset.
  task automatic t_regs();
    logic [7:0] a[5] = '{8'h42, 8'h44, 8'h45, 8'h46, 8'h47};
    logic [7:0] m[5] = '{8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h1E};
    foreach (a[i]) begin
      rd_chk(a[i], 8'h00);
      cfg_acc(1'h1, a[i], 8'hFF, 1'h1);
      rd_chk(a[i], m[i]);
      cfg_acc(1'h1, a[i], 8'h00, 1'h1);
    end
    cfg_acc(1'h0, 8'h48, 8'h00, 1'h0);
    chk("unmapped", {8'h00, rd}, 16'h0000);
    $display("test regs done");
  endtask

  // Plane loss, failure capture and the soft-off bit.
  task automatic t_power();
    cfg_acc(1'h1, 8'h43, 8'h40, 1'h1);
    tick(2);
    chk("soft_off", {15'h0000, soft_off}, 16'h0001);
    pins.aon_valid <= 1'h0;
    tick(5);
    cfg_acc(1'h0, 8'h43, 8'h00, 1'h1);
    chk("status", {15'h0000, rd[7]}, 16'h0001);
    pins.aon_valid <= 1'h1;
    from_state <= 3'h6;
    fon_entry <= 1'h1;
    tick(1);
    fon_entry <= 1'h0;
    tick(5);
    chk("soft_off", {15'h0000, soft_off}, 16'h0000);
    rd_chk(8'h43, 8'hA6);
    cfg_acc(1'h1, 8'h43, 8'h80, 1'h1);
    rd_chk(8'h43, 8'h26);
    cfg_acc(1'h1, 8'h43, 8'h40, 1'h1);
    port_rst <= 1'h1;
    tick(1);
    port_rst <= 1'h0;
    tick(2);
    chk("soft_off", {15'h0000, soft_off}, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      cur_state <= (k == 0) ? 3'h5 : 3'h2;
      mech_off <= 1'h1;
      tick(1);
      mech_off <= 1'h0;
      tick(2);
      rd_chk(8'h43, 8'h2E);
    end
    cfg_acc(1'h1, 8'h43, 8'h30, 1'h1);
    rd_chk(8'h43, 8'h2E);
    cfg_acc(1'h1, 8'h43, 8'h08, 1'h1);
    rd_chk(8'h43, 8'h26);
    cur_state <= 3'h3;
    pins.power_on_request_n <= 1'h0;
    pins.power_good <= 1'h0;
    tick(6);
    rd_chk(8'h43, 8'h1E);
    pins.power_on_request_n <= 1'h1;
    pins.power_good <= 1'h1;
    cfg_acc(1'h1, 8'h43, 8'h08, 1'h1);
    $display("test power done");
  endtask

  // Control interrupt line selection, enables and routing away.
  task automatic t_sci();
    gpio_ev <= 1'h1;
    mode <= 1'h1;
    for (int c = 0; c < 16; c++) begin
      if (c == 2 || c == 8 || c == 13) continue;
      cfg_acc(1'h1, 8'h42, 8'h10 | 8'(c), 1'h1);
      tick(2);
      chk("sci line", pic, (c == 0) ? 16'h0000 : 16'h0001 << c);
      if (c != 0) chk("sci req", {15'h0000, sci_req}, 16'h0001);
    end
    cfg_acc(1'h1, 8'h42, 8'h05, 1'h1);
    tick(2);
    chk("gpio off", pic, 16'h0000);
    gpio_ev <= 1'h0;
    trap_ev <= 1'h1;
    cfg_acc(1'h1, 8'h42, 8'h25, 1'h1);
    tick(2);
    chk("trap", pic, 16'h0020);
    mode <= 1'h0;
    tick(2);
    chk("smi", {15'h0000, smi_req}, 16'h0001);
    mode <= 1'h1;
    to_apic <= 1'h1;
    tick(2);
    chk("to apic", pic, 16'h0000);
    to_apic <= 1'h0;
    trap_ev <= 1'h0;
    cfg_acc(1'h1, 8'h42, 8'h00, 1'h1);
    $display("test sci done");
  endtask

  // Watchdog line codes, enable and routing to the control interrupt.
  task automatic t_wdog();
    wd_sts <= 1'h1;
    for (int c = 0; c < 8; c++) begin
      cfg_acc(1'h1, 8'h45, 8'h80 | 8'(c << 4), 1'h1);
      tick(2);
      chk("wdog pic", pic, (c < 3) ? 16'h0200 << c : 16'h0000);
      chk("wdog apic", {12'h000, apic}, (c > 3) ? 16'h0001 << (c - 4) : 16'h0000);
    end
    wd_to_ctl <= 1'h1;
    tick(2);
    chk("wdog to ctl", {12'h000, apic}, 16'h0000);
    wd_to_ctl <= 1'h0;
    cfg_acc(1'h1, 8'h45, 8'h00, 1'h1);
    tick(2);
    chk("wdog off", pic, 16'h0000);
    wd_sts <= 1'h0;
    $display("test wdog done");
  endtask

  // Plug-and-play interrupt pins and the IRQ12 pin roles.
  task automatic t_pins();
    cfg_acc(1'h1, 8'h44, 8'h75, 1'h1);
    cfg_acc(1'h1, 8'h45, 8'h0B, 1'h1);
    pins.pnp_irq <= 3'h7;
    pnp_en <= 3'h3;
    tick(5);
    chk("pnp gated", pic, 16'h00A0);
    pnp_en <= 3'h7;
    tick(2);
    chk("pnp all", pic, 16'h08A0);
    pins.pnp_irq <= 3'h0;
    pins.irq12 <= 1'h1;
    for (int f = 0; f < 4; f++) begin
      cfg_acc(1'h1, 8'h47, 8'(f << 1), 1'h1);
      tick(5);
      chk("irq12 line", pic, (f == 0) ? 16'h1000 : 16'h0000);
      chk("smb", {15'h0000, smb_n}, (f == 2) ? 16'h0000 : 16'h0001);
      chk("usb", {15'h0000, usb_n}, (f == 3) ? 16'h0000 : 16'h0001);
    end
    pins.irq12 <= 1'h0;
    $display("test pins done");
  endtask

  // Chip select decode, upper mask and cycle claiming.
  task automatic t_cs();
    cfg_acc(1'h1, 8'h46, 8'h0F, 1'h1);
    cfg_acc(1'h1, 8'h47, 8'h00, 1'h1);
    cs_en <= 2'h3;
    lo_a <= 1'h1;
    tick(2);
    chk("cs a upper", {15'h0000, cs_a_n}, 16'h0001);
    cfg_acc(1'h1, 8'h47, 8'h08, 1'h1);
    tick(2);
    chk("cs a io", {14'h0000, cs_a_n, claim}, 16'h0001);
    lo_a <= 1'h0;
    mem_b <= 1'h1;
    tick(2);
    chk("cs b mem", {14'h0000, cs_a_n, cs_b_n}, 16'h0002);
    cs_en <= 2'h1;
    mem_a <= 1'h1;
    tick(2);
    chk("cs a mem", {13'h0000, cs_a_n, cs_b_n, claim}, 16'h0003);
    mem_a <= 1'h0;
    mem_b <= 1'h0;
    lo_b <= 1'h1;
    up_b <= 1'h1;
    cs_en <= 2'h2;
    tick(2);
    chk("cs b io", {14'h0000, cs_b_n, claim}, 16'h0001);
    $display("test cs done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    {sci_src, gpio_ev, trap_ev, mode, to_apic, wd_sts, intr_sts, wd_to_ctl} = 8'h00;
    {lo_a, up_a, lo_b, up_b, mem_a, mem_b, mech_off, fon_entry, port_rst} = 9'h000;
    {pnp_en, cur_state, from_state, cs_en} = 11'h000;
    cfg = '0;
    pins = '{aon_valid: 1'h1, power_good: 1'h1, power_on_request_n: 1'h1, pnp_irq: 3'h0, irq12: 1'h0};
    i_srst = 1'h1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'h0;
    t_regs();
    t_power();
    t_sci();
    t_wdog();
    t_pins();
    t_cs();
    close_out();
  end
endmodule
